// file: pcp_pkg.sv
// Package: constants and types for the control-pin logic
package pcp_pkg;
  // Oscillator and system clock rates
  localparam int unsigned SYS_CLK_HZ = 250000000;
  localparam int unsigned SLOW_CLK_HZ = 32768;
  // Half period of the slow clock, in system cycles (rounded down)
  localparam int unsigned SLOW_HALF_CYC = SYS_CLK_HZ / (2 * SLOW_CLK_HZ);
  localparam int unsigned SLOW_DIV_W = 13;
  // Long press time in seconds and in slow-clock ticks
  localparam int unsigned LONG_PRESS_S = 12;
  localparam int unsigned LONG_PRESS_TICKS = LONG_PRESS_S * SLOW_CLK_HZ;
  localparam int unsigned PRESS_CNT_W = 20;
  // Qualification length for sleep-request pins, in system cycles
  localparam int unsigned QUAL_CYC = 4;
  localparam int unsigned QUAL_W = 3;
  // Reset hold after power up, in slow ticks
  localparam int unsigned RST_HOLD_TICKS = 4;
  localparam int unsigned RST_W = 3;
  // Three-level strap codes
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_DIG = 2'h1;
  localparam logic [1:0] STRAP_ANA = 2'h2;
  // Cable ID codes
  localparam logic [1:0] ID_FLOAT = 2'h0;
  localparam logic [1:0] ID_GND = 2'h1;
  localparam logic [1:0] ID_FACTORY = 2'h2;
  // ADC channel numbers
  localparam logic [2:0] ADC_CH4 = 3'h4;
  localparam logic [2:0] ADC_CH7 = 3'h7;
  // Power states, one-hot
  typedef enum logic [5:0] {
    PCP_OFF = 6'h01,
    PCP_COLD = 6'h02,
    PCP_WDOG = 6'h04,
    PCP_ON = 6'h08,
    PCP_STBY = 6'h10,
    PCP_RESTART = 6'h20
  } pcp_state_e;
  // Operating mode from the strap
  typedef enum logic [2:0] {
    PCP_NORMAL = 3'h1,
    PCP_USB_LP_BOOT = 3'h2,
    PCP_TEST = 3'h4
  } pcp_mode_e;
endpackage

// file: pcp_control_pins.sv
// Control-pin logic: standby, keep-alive, power keys, straps, clocks, resets, muxes
`timescale 1ns/1ps
module pcp_control_pins (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic host_sleep_request, // Processor sleep pin
  input wire logic periph_sleep_request, // Peripheral sleep pin
  input wire logic host_sleep_pol, // 1: host request active high
  input wire logic periph_sleep_pol, // 1: peripheral request active high
  input wire logic [7:0] irq_pending, // Pending event bits
  input wire logic [7:0] irq_mask, // 1 masks the event
  input wire logic keepalive_in, // Keep-alive pin
  input wire logic keepalive_to_cold, // 1: keep-alive loss goes to Cold Start
  input wire logic power_key1_in, // Power key pin 1, low pressed
  input wire logic power_key2_in, // Power key pin 2, low pressed
  input wire logic power_key3_in, // Power key pin 3, low pressed
  input wire logic restart_variant_a, // Variant strap: restart on by default
  input wire logic full_restart_enable_n, // Written enable bit, active low
  input wire logic full_restart_enable_wr, // Pulse: enable bit written
  input wire logic startup_done, // Start-up sequence finished
  input wire logic power_off_req, // Software off request
  input wire logic low_power_off, // Low Power Off mode active
  input wire logic host_clk_gate_en, // Allow host clock gating in low-power off
  input wire logic host_reset_hold, // Hold host in reset
  input wire logic periph_reset_hold, // Hold peripherals in reset
  input wire logic chip_select_pin, // Chip select / config pin
  input wire logic spi_clk_pin, // SPI clock / SCL pin
  input wire logic spi_din_pin, // SPI data in / address pin
  input wire logic spi_dout_data, // Serial core data out
  input wire logic spi_dout_oe, // Serial core data out enable
  input wire logic sda_drive_low, // I2C core pulls SDA low
  input wire logic spi_dout_pin_in, // Data out pin level
  input wire logic [1:0] mode_strap, // Three-level strap code
  input wire logic usb_ldo_input_select, // Connect cable supply to USB LDO input
  input wire logic cable_id_float, // Comparator: ID floating
  input wire logic cable_id_factory, // Comparator: ID factory level
  input wire logic general_out4_adc_sel, // General out 4 to ADC channel 7
  input wire logic touch_active, // Touch interface active
  output pcp_pkg::pcp_state_e power_state, // Power state
  output logic standby_event, // Qualified standby event
  output logic host_irq, // Interrupt to processor
  output logic turn_on_event, // One-cycle turn-on pulse
  output logic full_restart, // One-cycle restart pulse
  output logic charger_disable, // Charger off during restart
  output logic regs_to_default, // Pulse: registers to defaults
  output logic i2c_mode, // 1: I2C host mode latched
  output logic spi_cs_active, // Qualified SPI chip select
  output logic scl_in, // SCL to I2C core
  output logic sda_in, // SDA to I2C core
  output logic spi_dout_pin_out, // Data out pin value
  output logic spi_dout_pin_oe, // Data out pin enable
  output logic i2c_addr_sel, // I2C address select bit
  output pcp_pkg::pcp_mode_e op_mode, // Operating mode
  output logic periph_slow_clk_out, // Peripheral 32 kHz clock
  output logic host_slow_clk_out, // Host 32 kHz clock
  output logic periph_reset_n, // Peripheral reset, active low
  output logic host_reset_n, // Host reset, active low
  output logic usb_switch_on, // Cable supply switch to USB LDO input
  output logic [1:0] cable_id_sense, // Cable ID sense code
  output logic adc_ch7_alt_sel, // Channel 7 second input select
  output logic touch_gp_adc_en, // Plates routed as ADC inputs
  output logic [2:0] touch_adc_base // First ADC channel of the plates
);
  import pcp_pkg::*;

  // Two-flop synchronisers for all pin inputs
  localparam int NSYNC = 10;
  wire [NSYNC-1:0] pin_raw = {spi_dout_pin_in, host_sleep_request, periph_sleep_request,
    keepalive_in,
    power_key1_in, power_key2_in, power_key3_in, chip_select_pin, spi_din_pin,
    spi_clk_pin};
  logic [NSYNC-1:0] sync1_r, sync2_r;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          sync1_r[gi] <= 1'b1;
          sync2_r[gi] <= 1'b1;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate
  wire sda_s = sync2_r[9];
  wire hs_s = sync2_r[8];
  wire ps_s = sync2_r[7];
  wire ka_s = sync2_r[6];
  wire k1_s = sync2_r[5];
  wire k2_s = sync2_r[4];
  wire k3_s = sync2_r[3];
  wire cs_s = sync2_r[2];
  wire din_s = sync2_r[1];
  wire clk_s = sync2_r[0];

  // Slow-clock tick divider
  logic [SLOW_DIV_W-1:0] div_r;
  logic slow_lvl_r;
  wire div_end = (div_r == SLOW_DIV_W'(SLOW_HALF_CYC - 1));
  wire slow_tick = div_end && slow_lvl_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= '0;
      slow_lvl_r <= 1'b0;
    end else begin
      div_r <= div_end ? '0 : div_r + 1'b1;
      if (div_end) slow_lvl_r <= ~slow_lvl_r;
    end
  end

  // Standby qualification: level must persist before use
  wire host_req = ~(hs_s ^ host_sleep_pol);
  wire periph_req = ~(ps_s ^ periph_sleep_pol);
  wire both_req = host_req && periph_req;
  logic both_prev_r, stby_q_r;
  logic [QUAL_W-1:0] qual_r;
  wire qual_done = (qual_r == QUAL_W'(QUAL_CYC - 1));
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      both_prev_r <= 1'b0;
      qual_r <= '0;
      stby_q_r <= 1'b0;
    end else begin
      both_prev_r <= both_req;
      if (both_req != both_prev_r) qual_r <= '0;
      else if (!qual_done) qual_r <= qual_r + 1'b1;
      if (qual_done) stby_q_r <= both_prev_r;
    end
  end

  // Power key 3 long-press timer on slow ticks
  logic [PRESS_CNT_W-1:0] press_r;
  logic k3_prev_r, restart_en_r, restart_init_r, long_r;
  wire k3_fall = k3_prev_r && !k3_s;
  wire k3_rise = !k3_prev_r && k3_s;
  wire long_hit = (press_r >= PRESS_CNT_W'(LONG_PRESS_TICKS));
  wire restart_go = k3_rise && long_r && restart_en_r;
  wire key_on = (!k1_s || !k2_s || k3_fall) && !restart_go;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      press_r <= '0;
      k3_prev_r <= 1'b1;
      long_r <= 1'b0;
    end else begin
      k3_prev_r <= k3_s;
      if (k3_fall) press_r <= '0;
      else if (!k3_s && slow_tick && !long_hit) press_r <= press_r + 1'b1;
      long_r <= !k3_s && long_hit;
    end
  end
  // Default enable taken after reset release from the variant strap
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      restart_init_r <= 1'b0;
      restart_en_r <= 1'b0;
    end else begin
      restart_init_r <= 1'b1;
      if (!restart_init_r) restart_en_r <= restart_variant_a;
      else if (full_restart_enable_wr) restart_en_r <= !full_restart_enable_n;
    end
  end

  // Power state machine
  pcp_state_e st_r, st_nxt;
  wire in_on = (st_r == PCP_ON) || (st_r == PCP_STBY);
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      PCP_OFF: if (key_on) st_nxt = PCP_COLD;
      PCP_COLD: if (startup_done) st_nxt = PCP_WDOG;
      PCP_WDOG: if (ka_s) st_nxt = PCP_ON;
      PCP_ON, PCP_STBY: begin
        if (!ka_s) st_nxt = keepalive_to_cold ? PCP_COLD : PCP_OFF;
        else if (power_off_req) st_nxt = PCP_OFF;
        else st_nxt = stby_q_r ? PCP_STBY : PCP_ON;
      end
      PCP_RESTART: st_nxt = PCP_COLD;
      default: st_nxt = PCP_OFF;
    endcase
    if (restart_go) st_nxt = PCP_RESTART;
  end

  // Interface strap latched on entry to Cold Start
  wire cold_entry = (st_nxt == PCP_COLD) && (st_r != PCP_COLD);
  logic i2c_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) i2c_r <= 1'b0;
    else if (cold_entry) i2c_r <= cs_s;
  end

  // Reset hold counter after power up
  logic [RST_W-1:0] rst_cnt_r;
  wire rst_done = (rst_cnt_r == RST_W'(RST_HOLD_TICKS));
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) rst_cnt_r <= '0;
    else if (!in_on && st_r != PCP_WDOG) rst_cnt_r <= '0;
    else if (slow_tick && !rst_done) rst_cnt_r <= rst_cnt_r + 1'b1;
  end

  // Combinational pin and mux decode
  wire [1:0] id_nxt = cable_id_factory ? ID_FACTORY : (cable_id_float ? ID_FLOAT : ID_GND);
  pcp_mode_e mode_nxt;
  assign mode_nxt = (mode_strap == STRAP_ANA) ? PCP_TEST :
                    (mode_strap == STRAP_DIG) ? PCP_USB_LP_BOOT : PCP_NORMAL;
  wire powered = (st_r != PCP_OFF) && (st_r != PCP_RESTART);
  wire host_clk_nxt = powered && slow_lvl_r && !(low_power_off && host_clk_gate_en);
  wire dout_oe_nxt = i2c_r ? sda_drive_low : (spi_dout_oe && cs_s);

  // Output registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= PCP_OFF;
      power_state <= PCP_OFF;
      standby_event <= 1'b0;
      host_irq <= 1'b0;
      turn_on_event <= 1'b0;
      full_restart <= 1'b0;
      charger_disable <= 1'b0;
      regs_to_default <= 1'b0;
      i2c_mode <= 1'b0;
      spi_cs_active <= 1'b0;
      scl_in <= 1'b1;
      sda_in <= 1'b1;
      spi_dout_pin_out <= 1'b0;
      spi_dout_pin_oe <= 1'b0;
      i2c_addr_sel <= 1'b0;
      op_mode <= PCP_NORMAL;
      periph_slow_clk_out <= 1'b0;
      host_slow_clk_out <= 1'b0;
      periph_reset_n <= 1'b0;
      host_reset_n <= 1'b0;
      usb_switch_on <= 1'b0;
      cable_id_sense <= ID_FLOAT;
      adc_ch7_alt_sel <= 1'b0;
      touch_gp_adc_en <= 1'b0;
      touch_adc_base <= ADC_CH4;
    end else begin
      st_r <= st_nxt;
      power_state <= st_nxt;
      standby_event <= stby_q_r && in_on;
      host_irq <= |(irq_pending & ~irq_mask);
      turn_on_event <= key_on && (st_r == PCP_OFF);
      full_restart <= restart_go;
      charger_disable <= restart_go || (st_r == PCP_RESTART);
      regs_to_default <= restart_go;
      i2c_mode <= i2c_r;
      spi_cs_active <= !i2c_r && cs_s;
      scl_in <= i2c_r ? clk_s : 1'b1;
      sda_in <= i2c_r ? sda_s : 1'b1;
      spi_dout_pin_out <= i2c_r ? 1'b0 : spi_dout_data;
      spi_dout_pin_oe <= dout_oe_nxt;
      if (cold_entry) i2c_addr_sel <= din_s;
      op_mode <= mode_nxt;
      periph_slow_clk_out <= powered && slow_lvl_r;
      host_slow_clk_out <= host_clk_nxt;
      periph_reset_n <= rst_done && in_on && !periph_reset_hold;
      host_reset_n <= rst_done && in_on && !host_reset_hold;
      usb_switch_on <= usb_ldo_input_select;
      cable_id_sense <= id_nxt;
      adc_ch7_alt_sel <= general_out4_adc_sel;
      touch_gp_adc_en <= !touch_active;
      touch_adc_base <= ADC_CH4;
    end
  end
endmodule

// file: pcp_control_pins_assertions.sv
// Checker for the control-pin logic, bound to its top module
`timescale 1ns/1ps
module pcp_control_pins_checker (
  input wire logic sys_clk, // Clock
  input wire logic rstn, // Reset
  input wire logic host_sleep_request, // Pin
  input wire logic periph_sleep_request, // Pin
  input wire logic host_sleep_pol, // Polarity
  input wire logic periph_sleep_pol, // Polarity
  input wire logic [7:0] irq_pending, // Events
  input wire logic [7:0] irq_mask, // Masks
  input wire logic keepalive_in, // Pin
  input wire logic power_key1_in, // Pin
  input wire logic host_reset_hold, // Hold
  input pcp_pkg::pcp_state_e power_state, // State
  input wire logic standby_event, // Standby
  input wire logic host_irq, // Interrupt
  input wire logic turn_on_event, // Turn-on
  input wire logic full_restart, // Restart
  input wire logic charger_disable, // Charger off
  input wire logic regs_to_default, // Defaults
  input wire logic host_reset_n // Host reset
);
  import pcp_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_irq; $past(rstn) |-> host_irq == $past(|(irq_pending & ~irq_mask)); endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_stby_on; $rose(standby_event) |-> $past(power_state) == PCP_ON; endproperty
  a_stby_on: assert property (p_stby_on) else $error("standby outside On");
  property p_stby_both;
    $rose(standby_event) |-> $past(host_sleep_request == host_sleep_pol, 4)
      && $past(periph_sleep_request == periph_sleep_pol, 4);
  endproperty
  a_stby_both: assert property (p_stby_both) else $error("standby cause");
  property p_ton; $fell(power_key1_in) && power_state == PCP_OFF |-> ##[2:5] turn_on_event; endproperty
  a_ton: assert property (p_ton) else $error("no turn-on");
  property p_pulse; turn_on_event |=> !turn_on_event; endproperty
  a_pulse: assert property (p_pulse) else $error("turn-on too long");
  property p_restart; full_restart |-> regs_to_default && charger_disable; endproperty
  a_restart: assert property (p_restart) else $error("restart incomplete");
  property p_ka; !keepalive_in [*6] |-> !(power_state inside {PCP_ON, PCP_STBY}); endproperty
  a_ka: assert property (p_ka) else $error("keep-alive loss ignored");
  property p_hold; host_reset_hold [*2] |-> !host_reset_n; endproperty
  a_hold: assert property (p_hold) else $error("host reset not held");
  c_stby: cover property ($rose(standby_event));
  c_ton: cover property (turn_on_event);
  c_run: cover property ($rose(host_reset_n));
endmodule
bind pcp_control_pins pcp_control_pins_checker pcp_control_pins_checker_i (.*);

// file: pcp_host_model.sv
// Processor and peripheral side: sleep pins, keep-alive, config pin
`timescale 1ns/1ps
module pcp_host_model (
  input wire logic sys_clk, // Clock
  input wire logic host_sleep_pol, // Host polarity
  input wire logic periph_sleep_pol, // Peripheral polarity
  input wire logic host_sleep_on, // Host allows standby
  input wire logic periph_sleep_on, // Peripherals allow standby
  input wire logic alive, // Host software running
  input wire logic use_i2c, // Config pin tied to core rail
  output logic host_sleep_request, // Pin
  output logic periph_sleep_request, // Pin
  output logic keepalive_in, // Pin
  output logic chip_select_pin // Pin
);
  initial {host_sleep_request, periph_sleep_request, keepalive_in, chip_select_pin} = 4'h0;
  always @(posedge sys_clk) begin
    host_sleep_request <= #1 host_sleep_on ~^ host_sleep_pol;
    periph_sleep_request <= #1 periph_sleep_on ~^ periph_sleep_pol;
    keepalive_in <= #1 alive;
    // Low by host and pull-down unless rail-tied
    chip_select_pin <= #1 use_i2c;
  end
endmodule

// file: pcp_control_pins_tb.sv
// Self-checking bench for the control-pin logic
`timescale 1ns/1ps
module pcp_control_pins_tb;
  import pcp_pkg::*;
  logic sys_clk, rstn, host_sleep_pol, periph_sleep_pol, keepalive_to_cold, restart_variant_a;
  logic full_restart_enable_n, full_restart_enable_wr, startup_done, power_off_req;
  logic low_power_off, host_clk_gate_en, host_reset_hold, periph_reset_hold, spi_clk_pin;
  logic spi_din_pin, spi_dout_data, spi_dout_oe, sda_drive_low, spi_dout_pin_in;
  logic usb_ldo_input_select, cable_id_float, cable_id_factory, general_out4_adc_sel, touch_active;
  logic use_i2c, host_sleep_on, periph_sleep_on, alive, hprev, pprev;
  logic [7:0] irq_pending, irq_mask;
  logic [1:0] mode_strap, cable_id_sense;
  logic [3:1] keys;
  logic [2:0] touch_adc_base;
  wire logic power_key1_in = keys[1];
  wire logic power_key2_in = keys[2];
  wire logic power_key3_in = keys[3];
  logic host_sleep_request, periph_sleep_request, keepalive_in, chip_select_pin;
  pcp_state_e power_state;
  pcp_mode_e op_mode;
  logic standby_event, host_irq, turn_on_event, full_restart, charger_disable, regs_to_default;
  logic i2c_mode, spi_cs_active, scl_in, sda_in, spi_dout_pin_out, spi_dout_pin_oe, i2c_addr_sel;
  logic periph_slow_clk_out, host_slow_clk_out, periph_reset_n, host_reset_n, usb_switch_on;
  logic adc_ch7_alt_sel, touch_gp_adc_en;
  int mismatches, checked, cycles, ton_cnt, htg, ptg;
  pcp_control_pins pcp_control_pins_i (.*);
  pcp_host_model pcp_host_model_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (turn_on_event === 1'b1) ton_cnt++;
    if (host_slow_clk_out !== hprev) htg++;
    if (periph_slow_clk_out !== pprev) ptg++;
    hprev = host_slow_clk_out;
    pprev = periph_slow_clk_out;
    if (cycles == 80000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_state(input pcp_state_e s, input int lim);
    for (int i = 0; i < lim && power_state !== s; i++) step(1);
    chk("state", 8'(s), 8'(power_state));
  endtask
  task automatic power_up(input int k, input logic i2c);
    int base;
    base = ton_cnt;
    use_i2c = i2c;
    startup_done = 1'b0;
    step(4);
    keys[k] = 1'b0;
    step(8);
    chk("ton", 8'(base + 1), 8'(ton_cnt));
    wait_state(PCP_COLD, 10);
    keys[k] = 1'b1;
    chk("i2c", 8'(i2c), 8'(i2c_mode));
    startup_done = 1'b1;
    wait_state(PCP_WDOG, 10);
  endtask
  initial begin
    int h;
    int p;
    {rstn, host_sleep_pol, periph_sleep_pol, keepalive_to_cold, restart_variant_a} = '0;
    {full_restart_enable_wr, startup_done, power_off_req, low_power_off, host_clk_gate_en} = '0;
    {host_reset_hold, periph_reset_hold, spi_clk_pin, spi_din_pin, spi_dout_data} = '0;
    {spi_dout_oe, sda_drive_low, spi_dout_pin_in, usb_ldo_input_select, cable_id_float} = '0;
    {cable_id_factory, general_out4_adc_sel, touch_active, use_i2c, host_sleep_on, periph_sleep_on} = '0;
    {alive, irq_pending, irq_mask, mode_strap} = '0;
    full_restart_enable_n = 1'b1;
    keys = 3'h7;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("rst", 8'h00, {6'h0, host_reset_n, periph_reset_n});
    rstn = 1'b1;
    step(1);
    full_restart_enable_n = 1'b0;
    full_restart_enable_wr = 1'b1;
    step(1);
    full_restart_enable_wr = 1'b0;
    for (int i = 0; i < 4; i++) begin
      mode_strap = (i == 3) ? 2'h2 : 2'(i);
      cable_id_float = (i == 0) || (i == 3);
      cable_id_factory = (i >= 2);
      irq_pending = 8'h01 << i;
      irq_mask = (i % 2 == 1) ? irq_pending : 8'h00;
      {usb_ldo_input_select, touch_active, spi_dout_data} = {3{i[0]}};
      {general_out4_adc_sel, spi_dout_oe} = {2{i[1]}};
      step(4);
      chk("mode", (i == 3) ? 8'h04 : 8'h01 << i, 8'(op_mode));
      chk("id", (i == 3) ? 8'h02 : 8'(i), 8'(cable_id_sense));
      chk("irq", 8'(i % 2 == 0), 8'(host_irq));
      chk("usb", 8'(i[0]), 8'(usb_switch_on));
      chk("adc7", 8'(i[1]), 8'(adc_ch7_alt_sel));
      chk("touch", {4'h0, ~i[0], 3'h4}, {4'h0, touch_gp_adc_en, touch_adc_base});
    end
    {host_sleep_pol, periph_sleep_pol, host_sleep_on, periph_sleep_on} = 4'hF;
    power_up(1, 1'b0);
    step(20);
    chk("stby", 8'h00, 8'(standby_event));
    h = htg;
    alive = 1'b1;
    wait_state(PCP_STBY, 30);
    step(1);
    chk("stbyev", 8'h01, 8'(standby_event));
    for (int i = 0; i < 32000 && host_reset_n !== 1'b1; i++) step(1);
    chk("run", 8'h03, {6'h0, host_reset_n, periph_reset_n});
    use_i2c = 1'b1;
    step(5);
    chk("cs", 8'h01, 8'(spi_cs_active));
    use_i2c = 1'b0;
    chk("clk", 8'h01, 8'(htg - h >= 2 && ptg >= 2));
    for (int i = 0; i < 2; i++) begin
      {host_reset_hold, periph_reset_hold} = (i == 0) ? 2'h2 : 2'h1;
      step(4);
      chk("hold", (i == 0) ? 8'h01 : 8'h02, {6'h0, host_reset_n, periph_reset_n});
    end
    {host_reset_hold, periph_reset_hold} = 2'h0;
    {low_power_off, host_clk_gate_en} = 2'h3;
    step(4);
    h = htg;
    p = ptg;
    step(8000);
    chk("gate", 8'h01, 8'(htg == h && ptg - p >= 2));
    {low_power_off, host_clk_gate_en, keepalive_to_cold, alive} = 4'h0;
    wait_state(PCP_OFF, 10);
    {host_sleep_on, periph_sleep_on, host_sleep_pol} = 3'h0;
    spi_din_pin = 1'b1;
    power_up(3, 1'b1);
    chk("addr", 8'h01, 8'(i2c_addr_sel));
    {use_i2c, spi_dout_pin_in, sda_drive_low, spi_clk_pin} = 4'h3;
    step(6);
    chk("i2c", 8'h1A, {3'h0, i2c_mode, scl_in, sda_in, spi_dout_pin_oe, spi_dout_pin_out});
    alive = 1'b1;
    wait_state(PCP_ON, 10);
    host_sleep_on = 1'b1;
    step(20);
    chk("stby", 8'h00, 8'(standby_event));
    periph_sleep_on = 1'b1;
    step(3);
    chk("lag", 8'(PCP_ON), 8'(power_state));
    wait_state(PCP_STBY, 20);
    {keepalive_to_cold, alive} = 2'h2;
    wait_state(PCP_COLD, 10);
    h = ton_cnt;
    keys[2] = 1'b0;
    step(10);
    chk("ton", 8'(h), 8'(ton_cnt));
    report_and_stop();
  end
endmodule
